/* File: src/aifb_pkg.sv */
// constants shared by the audio interrupt flag bank and its pulse generator
// assumes a single clk_sys domain at 125 MHz and a byte-wide register port
package aifb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] REG_SPARE_A = 8'h28;
  localparam logic [7:0] REG_SPARE_D = 8'h2b;
  localparam logic [7:0] REG_PB_LATCH = 8'h2c;
  localparam logic [7:0] REG_REC_LATCH = 8'h2d;
  localparam logic [7:0] REG_PB_LIVE = 8'h2e;
  localparam logic [7:0] REG_REC_LIVE = 8'h2f;
  localparam int NUM_SPARE = 4;
  localparam logic [7:0] SPARE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions, shared by the latched and live views except BIT_REC_DC, which only the live record view uses
  localparam int BIT_PB_SHORT = 7;
  localparam int BIT_PB_BUTTON = 5;
  localparam int BIT_PB_HEADSET = 4;
  localparam int BIT_PB_COMP = 3;
  localparam int BIT_PB_STD = 1;
  localparam int BIT_PB_AUX = 0;
  localparam int BIT_REC_NOISE = 6;
  localparam int BIT_REC_STD = 4;
  localparam int BIT_REC_AUX = 3;
  localparam int BIT_REC_DC = 2;

  ////////////////////////////////////////////////////////////////////////////
  // source indices into the sampled source vector
  localparam int SRC_SHORT = 0;
  localparam int SRC_BUTTON = 1;
  localparam int SRC_HEADSET = 2;
  localparam int SRC_COMP = 3;
  localparam int SRC_NOISE_LE = 4;
  localparam int SRC_NOISE_LT = 5;
  localparam int SRC_PB_STD = 6;
  localparam int SRC_PB_AUX = 7;
  localparam int SRC_REC_STD = 8;
  localparam int SRC_REC_AUX = 9;
  localparam int SRC_DC = 10;
  localparam int NUM_SRC = 11;
  localparam int NUM_PIN = 2;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin timing
  localparam int CLK_KHZ = 125000;
  localparam int PULSE_MS = 2;
  localparam int PERIOD_MS = 4;
  localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
  localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    AIFB_IDLE = 2'b00,
    AIFB_HIGH = 2'b01,
    AIFB_LOW = 2'b11
  } aifb_pulse_state_t;

endpackage

/* File: src/aifb_pulse_gen.sv */
// one interrupt pin: single or repeated active-high pulse
// assumes start is a one-cycle pulse and reads are one-cycle strobes
module aifb_pulse_gen #(
  parameter int PULSE_CYCLES = aifb_pkg::PULSE_CYC,
  parameter int PERIOD_CYCLES = aifb_pkg::PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire logic repeat_mode,
  input wire logic rd_playback,
  input wire logic rd_record,
  output logic pin_out
);
  import aifb_pkg::*;

  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam logic [CW-1:0] HIGH_LAST = CW'(PULSE_CYCLES - 1);
  localparam logic [CW-1:0] LOW_LAST = CW'(PERIOD_CYCLES - PULSE_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  aifb_pulse_state_t state;
  logic [CW-1:0] cnt;
  logic seen_pb;
  logic seen_rec;
  logic done_reads;

  assign done_reads = seen_pb & seen_rec;

  ////////////////////////////////////////////////////////////////////////////
  // a new event restarts the wait for both latch reads
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen_pb <= 1'b0;
      seen_rec <= 1'b0;
    end else if (start) begin
      seen_pb <= 1'b0;
      seen_rec <= 1'b0;
    end else begin
      seen_pb <= seen_pb | rd_playback;
      seen_rec <= seen_rec | rd_record;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse train control
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= AIFB_IDLE;
      cnt <= CNT_ZERO;
    end else begin
      case (state)
        AIFB_IDLE: begin
          cnt <= CNT_ZERO;
          if (start) begin
            state <= AIFB_HIGH;
          end
        end
        AIFB_HIGH: begin
          if (cnt == HIGH_LAST) begin
            cnt <= CNT_ZERO;
            if (repeat_mode && !done_reads) begin
              state <= AIFB_LOW;
            end else begin
              state <= AIFB_IDLE;
            end
          end else begin
            cnt <= cnt + CNT_ONE;
          end
        end
        AIFB_LOW: begin
          if (!repeat_mode || done_reads) begin
            cnt <= CNT_ZERO;
            state <= AIFB_IDLE;
          end else if (cnt == LOW_LAST) begin
            cnt <= CNT_ZERO;
            state <= AIFB_HIGH;
          end else begin
            cnt <= cnt + CNT_ONE;
          end
        end
        default: begin
          cnt <= CNT_ZERO;
          state <= AIFB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= (state == AIFB_HIGH);
    end
  end

endmodule

/* File: src/aifb_top.sv */
// interrupt flag bank: sticky event latches, live status, spare registers
// and the two interrupt pin pulse generators
// assumes all event inputs are synchronous levels on clk_sys; the pin
// triggers arrive already masked by the enable logic outside this block
module aifb_top #(
  parameter int PULSE_CYCLES = aifb_pkg::PULSE_CYC,
  parameter int PERIOD_CYCLES = aifb_pkg::PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // event sources, all levels
  input wire logic short_detect,
  input wire logic button_pressed,
  input wire logic headset_inserted,
  input wire logic comp_power_above,
  input wire logic gain_ctl_at_or_below,
  input wire logic gain_ctl_below,
  input wire logic pb_engine_std_irq,
  input wire logic pb_engine_aux_irq,
  input wire logic rec_engine_std_irq,
  input wire logic rec_engine_aux_irq,
  input wire logic dc_meas_ready,
  // interrupt pin triggers and modes
  input wire logic first_pin_trigger,
  input wire logic first_pin_repeat,
  input wire logic second_pin_trigger,
  input wire logic second_pin_repeat,
  output logic first_interrupt_pin,
  output logic second_interrupt_pin
);
  import aifb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] src_now;
  logic [NUM_SRC-1:0] src_prev;
  logic [NUM_SRC-1:0] src_fire;
  logic [7:0] pb_latch;
  logic [7:0] rec_latch;
  logic [7:0] pb_live;
  logic [7:0] rec_live;
  logic [7:0] pb_set;
  logic [7:0] rec_set;
  logic [7:0] spare [NUM_SPARE];
  logic rd_pb_latch;
  logic rd_rec_latch;
  logic [7:0] next_rdata;
  logic [NUM_PIN-1:0] pin_trig;
  logic [NUM_PIN-1:0] pin_trig_prev;
  logic [NUM_PIN-1:0] pin_rep;
  logic [NUM_PIN-1:0] pin_drive;

  ////////////////////////////////////////////////////////////////////////////
  // gather sources into one vector
  always_comb begin
    src_raw = '0;
    src_raw[SRC_SHORT] = short_detect;
    src_raw[SRC_BUTTON] = button_pressed;
    src_raw[SRC_HEADSET] = headset_inserted;
    src_raw[SRC_COMP] = comp_power_above;
    src_raw[SRC_NOISE_LE] = gain_ctl_at_or_below;
    src_raw[SRC_NOISE_LT] = gain_ctl_below;
    src_raw[SRC_PB_STD] = pb_engine_std_irq;
    src_raw[SRC_PB_AUX] = pb_engine_aux_irq;
    src_raw[SRC_REC_STD] = rec_engine_std_irq;
    src_raw[SRC_REC_AUX] = rec_engine_aux_irq;
    src_raw[SRC_DC] = dc_meas_ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample every source and keep last cycle's value for edge detection
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          src_now[gi] <= 1'b0;
          src_prev[gi] <= 1'b0;
        end else begin
          src_now[gi] <= src_raw[gi];
          src_prev[gi] <= src_now[gi];
        end
      end
      // fire only on a new event
      if (gi == SRC_HEADSET) begin : g_both
        // insertion and removal both count as an event
        assign src_fire[gi] = src_now[gi] ^ src_prev[gi];
      end else begin : g_rise
        // a level that stays high does not re-arm a cleared flag
        assign src_fire[gi] = src_now[gi] & ~src_prev[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // set vectors for the two latched registers
  always_comb begin
    pb_set = BYTE_ZERO;
    pb_set[BIT_PB_SHORT] = src_fire[SRC_SHORT];
    pb_set[BIT_PB_BUTTON] = src_fire[SRC_BUTTON];
    pb_set[BIT_PB_HEADSET] = src_fire[SRC_HEADSET];
    pb_set[BIT_PB_COMP] = src_fire[SRC_COMP];
    pb_set[BIT_PB_STD] = src_fire[SRC_PB_STD];
    pb_set[BIT_PB_AUX] = src_fire[SRC_PB_AUX];
  end

  always_comb begin
    rec_set = BYTE_ZERO;
    // noise threshold latch, at or below
    rec_set[BIT_REC_NOISE] = src_fire[SRC_NOISE_LE];
    rec_set[BIT_REC_STD] = src_fire[SRC_REC_STD];
    rec_set[BIT_REC_AUX] = src_fire[SRC_REC_AUX];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read strobes of the latched registers
  assign rd_pb_latch = reg_rd && (reg_addr == REG_PB_LATCH);
  assign rd_rec_latch = reg_rd && (reg_addr == REG_REC_LATCH);

  ////////////////////////////////////////////////////////////////////////////
  // playback latched flags
  // the read captures the old value into reg_rdata in the same edge that
  // clears, so nothing is reported twice and nothing set later is dropped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pb_latch <= BYTE_ZERO;
    end else if (rd_pb_latch) begin
      pb_latch <= pb_set;
    end else begin
      pb_latch <= pb_latch | pb_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // record latched flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rec_latch <= BYTE_ZERO;
    end else if (rd_rec_latch) begin
      rec_latch <= rec_set;
    end else begin
      rec_latch <= rec_latch | rec_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live playback status, never cleared by a read
  always_comb begin
    pb_live = BYTE_ZERO;
    pb_live[BIT_PB_SHORT] = src_now[SRC_SHORT];
    pb_live[BIT_PB_BUTTON] = src_now[SRC_BUTTON];
    pb_live[BIT_PB_HEADSET] = src_now[SRC_HEADSET];
    pb_live[BIT_PB_COMP] = src_now[SRC_COMP];
    pb_live[BIT_PB_STD] = src_now[SRC_PB_STD];
    pb_live[BIT_PB_AUX] = src_now[SRC_PB_AUX];
  end

  ////////////////////////////////////////////////////////////////////////////
  // live record status
  always_comb begin
    rec_live = BYTE_ZERO;
    rec_live[BIT_REC_NOISE] = src_now[SRC_NOISE_LT];
    rec_live[BIT_REC_STD] = src_now[SRC_REC_STD];
    rec_live[BIT_REC_AUX] = src_now[SRC_REC_AUX];
    rec_live[BIT_REC_DC] = src_now[SRC_DC];
  end

  ////////////////////////////////////////////////////////////////////////////
  // spare registers: plain storage
  // software keeps them at reset contents; the hardware does not
  // police this, it just stores what it is given
  generate
    for (gi = 0; gi < NUM_SPARE; gi++) begin : g_spare
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          spare[gi] <= SPARE_RESET;
        end else if (reg_wr && (reg_addr == REG_SPARE_A + 8'(gi))) begin
          spare[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  // flag registers have no write path; gaps read zero
  always_comb begin
    next_rdata = BYTE_ZERO;
    if (reg_addr >= REG_SPARE_A && reg_addr <= REG_SPARE_D) begin
      next_rdata = spare[reg_addr[1:0]];
    end else begin
      case (reg_addr)
        REG_PB_LATCH: begin
          next_rdata = pb_latch;
        end
        REG_REC_LATCH: begin
          next_rdata = rec_latch;
        end
        REG_PB_LIVE: begin
          next_rdata = pb_live;
        end
        REG_REC_LIVE: begin
          next_rdata = rec_live;
        end
        default: begin
          next_rdata = BYTE_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and valid, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= BYTE_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pins
  assign pin_trig[0] = first_pin_trigger;
  assign pin_trig[1] = second_pin_trigger;
  assign pin_rep[0] = first_pin_repeat;
  assign pin_rep[1] = second_pin_repeat;

  generate
    for (gi = 0; gi < NUM_PIN; gi++) begin : g_pin
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          pin_trig_prev[gi] <= 1'b0;
        end else begin
          pin_trig_prev[gi] <= pin_trig[gi];
        end
      end
      // pulses stop once both latches are read
      aifb_pulse_gen #(
        .PULSE_CYCLES(PULSE_CYCLES),
        .PERIOD_CYCLES(PERIOD_CYCLES)
      ) u_pulse (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(pin_trig[gi] & ~pin_trig_prev[gi]),
        .repeat_mode(pin_rep[gi]),
        .rd_playback(rd_pb_latch),
        .rd_record(rd_rec_latch),
        .pin_out(pin_drive[gi])
      );
    end
  endgenerate

  assign first_interrupt_pin = pin_drive[0];
  assign second_interrupt_pin = pin_drive[1];

endmodule

/* File: verif/aifb_assertions.sv */
// port checker for the interrupt flag bank: read port, clears, pin pulse
// assumes it is bound to aifb_top with the same pulse parameters
module aifb_assertions #(
  parameter int PULSE_CYCLES = 8,
  parameter int PERIOD_CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic short_detect,
  input wire logic button_pressed,
  input wire logic headset_inserted,
  input wire logic comp_power_above,
  input wire logic pb_engine_std_irq,
  input wire logic pb_engine_aux_irq,
  input wire logic first_pin_trigger,
  input wire logic first_pin_repeat,
  input wire logic first_interrupt_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  import aifb_pkg::*;
  logic [5:0] pb_src;
  logic [5:0] last_src;
  logic [1:0] calm;
  logic [31:0] hi_cnt;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  assign pb_src = {short_detect, button_pressed, headset_inserted,
    comp_power_above, pb_engine_std_irq, pb_engine_aux_irq};

  // quiet sources mean no new event can race a clearing read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_src <= '0;
      calm <= '0;
    end else begin
      last_src <= pb_src;
      if (pb_src != last_src) begin
        calm <= 2'h0;
      end else if (calm != 2'h3) begin
        calm <= calm + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt <= '0;
    end else begin
      hi_cnt <= first_interrupt_pin ? hi_cnt + 32'h0000_0001 : '0;
    end
  end

  ////////////////////////////////////////////////////////////
  chk_read_answer:
    assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe without rvalid");
  chk_rvalid_cause:
    assert property (reg_rvalid |-> $past(reg_rd))
    else $error("rvalid without read strobe");
  chk_live_short:
    assert property ((reg_rd && reg_addr == REG_PB_LIVE
      && $stable(short_detect) && $past(rst_b, 3)
      && $past(short_detect, 2) == short_detect
      && $past(short_detect, 3) == short_detect)
      |=> reg_rdata[BIT_PB_SHORT] == $past(short_detect))
    else $error("live short bit wrong");
  chk_unmapped_zero:
    assert property ((reg_rd && (reg_addr < REG_SPARE_A
      || reg_addr > REG_REC_LIVE)) |=> reg_rdata == BYTE_ZERO)
    else $error("unmapped read not zero");
  chk_spare_bits_zero:
    assert property ((reg_rd && reg_addr == REG_PB_LATCH)
      |=> !reg_rdata[6] && !reg_rdata[2])
    else $error("reserved playback bits set");
  chk_clear_read:
    assert property ((reg_rd && reg_addr == REG_PB_LATCH && calm == 2'h3
      && $stable(pb_src)) ##1 (reg_rd && reg_addr == REG_PB_LATCH
      && $stable(pb_src)) |=> reg_rdata == BYTE_ZERO)
    else $error("flags survive a clearing read");
  chk_pulse_width:
    assert property ($fell(first_interrupt_pin) |-> hi_cnt == PULSE_CYCLES)
    else $error("pin pulse width wrong");
  chk_pin_start:
    assert property (($rose(first_pin_trigger) && !first_pin_repeat
      && !first_interrupt_pin) |-> ##[1:3] first_interrupt_pin)
    else $error("pin pulse did not start");
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the audio interrupt flag bank
// assumes aifb_top with pulse counts cut to 8 and 16 cycles
`define chk_eq(got, exp) begin \
  checked = checked + 1; \
  if ((got) !== (exp)) begin \
    err_total = err_total + 1; \
    $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import aifb_pkg::*;
  localparam int PULSE = 8;
  localparam int PERIOD = 16;
  typedef struct {
    int idx;
    logic [7:0] la;
    logic [7:0] lm;
    logic [7:0] va;
    logic [7:0] vm;
    logic both;
  } aifb_case_t;
  logic clk_sys, rst_b, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [10:0] src;
  logic trig1, rep1, trig2, rep2, pin1, pin2;
  int checked, err_total, hi, lo;
  // source, latch reg and bit, live reg and bit, sets on both edges
  aifb_case_t cases[11] = '{
    '{SRC_SHORT, 8'h2c, 8'h80, 8'h2e, 8'h80, 1'b0},
    '{SRC_BUTTON, 8'h2c, 8'h20, 8'h2e, 8'h20, 1'b0},
    '{SRC_HEADSET, 8'h2c, 8'h10, 8'h2e, 8'h10, 1'b1},
    '{SRC_COMP, 8'h2c, 8'h08, 8'h2e, 8'h08, 1'b0},
    '{SRC_PB_STD, 8'h2c, 8'h02, 8'h2e, 8'h02, 1'b0},
    '{SRC_PB_AUX, 8'h2c, 8'h01, 8'h2e, 8'h01, 1'b0},
    '{SRC_NOISE_LE, 8'h2d, 8'h40, 8'h2f, 8'h00, 1'b0},
    '{SRC_NOISE_LT, 8'h2d, 8'h00, 8'h2f, 8'h40, 1'b0},
    '{SRC_REC_STD, 8'h2d, 8'h10, 8'h2f, 8'h10, 1'b0},
    '{SRC_REC_AUX, 8'h2d, 8'h08, 8'h2f, 8'h08, 1'b0},
    '{SRC_DC, 8'h2c, 8'h00, 8'h2f, 8'h04, 1'b0}};

  aifb_top #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .short_detect(src[SRC_SHORT]), .button_pressed(src[SRC_BUTTON]),
    .headset_inserted(src[SRC_HEADSET]), .comp_power_above(src[SRC_COMP]),
    .gain_ctl_at_or_below(src[SRC_NOISE_LE]),
    .gain_ctl_below(src[SRC_NOISE_LT]),
    .pb_engine_std_irq(src[SRC_PB_STD]),
    .pb_engine_aux_irq(src[SRC_PB_AUX]),
    .rec_engine_std_irq(src[SRC_REC_STD]),
    .rec_engine_aux_irq(src[SRC_REC_AUX]), .dc_meas_ready(src[SRC_DC]),
    .first_pin_trigger(trig1), .first_pin_repeat(rep1),
    .second_pin_trigger(trig2), .second_pin_repeat(rep2),
    .first_interrupt_pin(pin1), .second_interrupt_pin(pin2));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    `chk_eq(reg_rvalid, 1'b1)
    `chk_eq(reg_rdata, e)
  endtask

  // two reads on consecutive edges, strobe held high between them
  task automatic rd_pair(input logic [7:0] a, input logic [7:0] e1,
      input logic [7:0] e2);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    `chk_eq(reg_rdata, e1)
    @(negedge clk_sys);
    reg_rd = 1'b0;
    `chk_eq(reg_rdata, e2)
  endtask

  function automatic logic pin(input logic w);
    return w ? pin2 : pin1;
  endfunction

  // bounded wait for a rise, then the high and following low spans
  task automatic pulse(input logic w);
    hi = 0;
    lo = 0;
    while (pin(w) !== 1'b1 && lo < 30) begin
      @(negedge clk_sys);
      lo++;
    end
    lo = 0;
    while (pin(w) === 1'b1 && hi < 100) begin
      @(negedge clk_sys);
      hi++;
    end
    while (pin(w) !== 1'b1 && lo < 40) begin
      @(negedge clk_sys);
      lo++;
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total = err_total + 1;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    src = '0;
    {trig1, rep1, trig2, rep2} = 4'h0;
    checked = 0;
    err_total = 0;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    for (int a = 8'h28; a <= 8'h31; a++) begin
      rdx(8'(a), BYTE_ZERO);
    end
    $display("test reset values done");
    for (int a = 8'h28; a <= 8'h2f; a++) begin
      wr(8'(a), (a < 8'h2c) ? SPARE_RESET : 8'hff);
    end
    for (int a = 8'h28; a <= 8'h2f; a++) begin
      rdx(8'(a), BYTE_ZERO);
    end
    $display("test writes done");
    foreach (cases[i]) begin
      src[cases[i].idx] = 1'b1;
      repeat (3) @(negedge clk_sys);
      rdx(cases[i].va, cases[i].vm);
      rdx(cases[i].la, cases[i].lm);
      rdx(cases[i].la, BYTE_ZERO);
      rdx(cases[i].va, cases[i].vm);
      src[cases[i].idx] = 1'b0;
      repeat (3) @(negedge clk_sys);
      rdx(cases[i].la, cases[i].both ? cases[i].lm : BYTE_ZERO);
      rdx(cases[i].va, BYTE_ZERO);
    end
    $display("test sources done");
    src[SRC_PB_STD] = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd_pair(REG_PB_LATCH, 8'h02, BYTE_ZERO);
    src[SRC_PB_STD] = 1'b0;
    src[SRC_PB_AUX] = 1'b1;
    // the event lands on the same edge as this clearing read
    rdx(REG_PB_LATCH, BYTE_ZERO);
    rdx(REG_PB_LATCH, 8'h01);
    src[SRC_PB_AUX] = 1'b0;
    $display("test clear race done");
    trig1 = 1'b1;
    pulse(1'b0);
    `chk_eq(hi, PULSE)
    `chk_eq(lo, 40)
    trig1 = 1'b0;
    rep2 = 1'b1;
    trig2 = 1'b1;
    pulse(1'b1);
    `chk_eq(hi, PULSE)
    `chk_eq(lo, PERIOD - PULSE)
    pulse(1'b1);
    `chk_eq(hi, PULSE)
    while (pin2 === 1'b1 && hi < 200) begin
      @(negedge clk_sys);
      hi++;
    end
    rdx(REG_PB_LATCH, BYTE_ZERO);
    rdx(REG_REC_LATCH, BYTE_ZERO);
    hi = 0;
    repeat (40) begin
      @(negedge clk_sys);
      hi = hi + ((pin2 !== 1'b0) ? 1 : 0);
    end
    `chk_eq(hi, 0)
    {trig2, rep2} = 2'h0;
    $display("test pins done");
    end_of_test();
  end
endmodule

bind aifb_top aifb_assertions #(.PULSE_CYCLES(PULSE_CYCLES),
  .PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .short_detect(short_detect), .button_pressed(button_pressed),
  .headset_inserted(headset_inserted), .comp_power_above(comp_power_above),
  .pb_engine_std_irq(pb_engine_std_irq),
  .pb_engine_aux_irq(pb_engine_aux_irq),
  .first_pin_trigger(first_pin_trigger),
  .first_pin_repeat(first_pin_repeat),
  .first_interrupt_pin(first_interrupt_pin));
